// >>> hw/rot_defines.vh
// register map, field positions, reset values and timing constants
// assumes: included by the rotation clock and stride block; apb byte address = index * 4
// Functional notes
// - rotation enable bit 7 low gives landscape refresh, high gives rotated refresh.
// - with rotation on, variant bit 6 picks default (0) or alternate (1).
// - divider select acts only when rotated; landscape pixel clock equals base clock.
// - landscape memory clock follows clock configuration bit 5.
// - default rotated: select 0..3 gives pixel and memory clock base/1,2,4,8.
// - alternate rotated: pixel base/2,2,4,8 with memory base/1,1,2,4.
// - base clock is input clock, or input clock halved when config bit 4 set.
// - rotated refresh advances each line start address by the stride.
// - stride value zero means 256 bytes between lines.
// - nonzero stride value n means exactly n bytes between lines.
// - horizontal active width is (7-bit field + 1) * 8 pixels.
// - horizontal blanking width is (5-bit field + 4) * 8 pixels.
// - vertical active height is 10-bit split field plus one lines.
// - vertical blanking height equals the 6-bit field, no offset.
// - frame lasts (width + hblank) * (height + vblank) pixel clocks.
// - video inversion applies after the colour look-up table.
// - monochrome depths translate only through the green look-up table.
`ifndef ROT_DEFINES_VH
`define ROT_DEFINES_VH
// register indices
`define IDX_CLK_CFG 8'h02
`define IDX_HACT 8'h04
`define IDX_VACT_LO 8'h05
`define IDX_VACT_HI 8'h06
`define IDX_HBLANK 8'h08
`define IDX_VBLANK 8'h0a
`define IDX_ROT 8'h1b
`define IDX_STRIDE 8'h1c
`define IDX_TEST_A 8'h1e
`define IDX_TEST_B 8'h1f
`define IDX_DISP 8'h20
`define IDX_LUT_IDX 8'h21
`define IDX_LUT_DATA 8'h22
`define IDX_FRAME_SIZE 8'h23
`define IDX_LINE_ADDR 8'h24
`define IDX_START 8'h25
// field positions
`define ROT_EN_BIT 7
`define ROT_ALT_BIT 6
`define ROT_WMASK 8'hc3
`define CFG_BASE_HALF_BIT 4
`define CFG_MEM_HALF_BIT 5
`define DISP_INV_BIT 0
`define DISP_MONO_BIT 1
// reset values
`define REG8_RESET 8'h00
`define START_RESET 17'h00000
// timing
`define HBLANK_OFS 5'h04
`define STRIDE_ZERO 9'h100
`endif

// >>> hw/lut_mem.v
// sixteen-entry colour look-up table, 4 bits each of red, green, blue
// assumes: one clock, write and read in the same domain, read data registered
`timescale 1ns/1ns
module lut_mem (
  input wire clk,
  input wire rst_n,
  input wire clk_en,
  input wire we,
  input wire [3:0] waddr,
  input wire [11:0] wdata,
  input wire [3:0] raddr,
  output wire [11:0] rdata
);
  reg [11:0] mem [0:15];
  reg [11:0] rdata_q;

  // table write port
  always @(posedge clk) begin
    if (clk_en && we) begin
      mem[waddr] <= wdata;
    end
  end

  // registered read port
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 12'h000;
    end else if (clk_en) begin
      rdata_q <= mem[raddr];
    end
  end

  assign rdata = rdata_q;
endmodule // lut_mem

// >>> hw/rotation_clock_stride_timing.v
// rotated refresh mode select, pixel/memory clock enables, line stride, frame timing, lut path
// assumes: apb master on pclk; refresh path on pclk consumes the enables and line address
`timescale 1ns/1ns
`include "rot_defines.vh"
module rotation_clock_stride_timing (
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [9:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire [31:0] prdata,
  output wire pslverr,
  input wire pixel_valid,
  input wire [3:0] pixel_in,
  output wire base_clk_en,
  output wire pixel_clk_en,
  output wire mem_clk_en,
  output wire [1:0] refresh_mode,
  output wire [8:0] line_stride,
  output wire [16:0] line_addr,
  output wire line_pulse,
  output wire frame_pulse,
  output wire out_valid,
  output wire [3:0] red_out,
  output wire [3:0] green_out,
  output wire [3:0] blue_out
);
  localparam MODE_LAND = 2'b00;
  localparam MODE_DEF = 2'b01;
  localparam MODE_ALT = 2'b10;

  // decode of mapped register indices
  function mapped;
    input [7:0] i;
    begin
      case (i)
        `IDX_CLK_CFG, `IDX_HACT, `IDX_VACT_LO, `IDX_VACT_HI, `IDX_HBLANK,
        `IDX_VBLANK, `IDX_ROT, `IDX_STRIDE, `IDX_TEST_A, `IDX_TEST_B,
        `IDX_DISP, `IDX_LUT_IDX, `IDX_LUT_DATA, `IDX_FRAME_SIZE,
        `IDX_LINE_ADDR, `IDX_START: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  endfunction

  // one tick every 2**lg base ticks
  function div_tick;
    input [2:0] cnt;
    input [1:0] lg;
    begin
      case (lg)
        2'd0: div_tick = 1'b1;
        2'd1: div_tick = (cnt[0] == 1'b0);
        2'd2: div_tick = (cnt[1:0] == 2'b00);
        default: div_tick = (cnt == 3'b000);
      endcase
    end
  endfunction

  // apb slave state and software registers
  reg pready_q;
  reg [31:0] prdata_q;
  reg pslverr_q;
  reg [7:0] clk_cfg_q;
  reg [6:0] hact_q;
  reg [7:0] vact_lo_q;
  reg [1:0] vact_hi_q;
  reg [4:0] hblank_q;
  reg [5:0] vblank_q;
  reg [7:0] rot_q;
  reg [7:0] stride_q;
  reg [1:0] disp_q;
  reg [3:0] lut_idx_q;
  reg [16:0] start_q;

  // base divider and clock enable outputs
  reg base_phase_q;
  reg [2:0] div_cnt_q;
  reg base_en_q;
  reg pix_en_q;
  reg mem_en_q;
  reg [1:0] mode_q;
  reg [8:0] stride_out_q;

  // frame geometry and refresh counters
  reg [10:0] h_total_q;
  reg [10:0] v_total_q;
  reg [20:0] frame_size_q;
  reg [10:0] hcnt_q;
  reg [10:0] vcnt_q;
  reg [16:0] line_addr_q;
  reg line_q;
  reg frame_q;

  // pixel output stage
  reg lut_v_q;
  reg out_v_q;
  reg [3:0] red_q;
  reg [3:0] green_q;
  reg [3:0] blue_q;

  // combinational next values
  reg [31:0] rd_d;
  reg [1:0] mode_d;
  reg [1:0] pix_lg_d;
  reg [1:0] mem_lg_d;

  // bus decode; a write lands only with pready high
  wire [7:0] idx = paddr[9:2];
  wire acc = psel & penable;
  wire wr_en = acc & pready_q & pwrite;
  wire lut_we = wr_en & (idx == `IDX_LUT_DATA);
  wire [11:0] lut_rd;
  wire rot_en = rot_q[`ROT_EN_BIT];
  wire rot_alt = rot_q[`ROT_ALT_BIT];
  wire [1:0] sel = rot_q[1:0];
  // frame geometry in pixels and lines
  wire [10:0] h_act = {1'b0, hact_q, 3'b000} + 11'h008;
  wire [10:0] h_blk = {3'b000, hblank_q, 3'b000} + {3'b000, `HBLANK_OFS, 3'b000};
  wire [10:0] v_act = {1'b0, vact_hi_q, vact_lo_q} + 11'h001;
  wire [10:0] v_blk = {5'h00, vblank_q};
  // zero stands for a full 256-byte line, hence nine bits
  wire [8:0] stride_d = (stride_q == 8'h00) ? `STRIDE_ZERO : {1'b0, stride_q};
  wire base_tick = ~clk_cfg_q[`CFG_BASE_HALF_BIT] | base_phase_q;
  // one shared counter keeps pixel and memory pulses aligned
  wire pix_tick = base_tick & div_tick(div_cnt_q, pix_lg_d);
  wire mem_tick = base_tick & div_tick(div_cnt_q, mem_lg_d);
  wire h_end = (hcnt_q >= h_total_q - 11'h001);
  wire v_end = (vcnt_q >= v_total_q - 11'h001);
  // product is one bit wider than the size register; the top bit never sets
  wire [21:0] frame_prod = h_total_q * v_total_q;

  // read data mux; factory test registers read as zero
  always @* begin
    rd_d = 32'h00000000;
    case (idx)
      `IDX_CLK_CFG: rd_d = {24'h000000, clk_cfg_q};
      `IDX_HACT: rd_d = {25'h0000000, hact_q};
      `IDX_VACT_LO: rd_d = {24'h000000, vact_lo_q};
      `IDX_VACT_HI: rd_d = {30'h00000000, vact_hi_q};
      `IDX_HBLANK: rd_d = {27'h0000000, hblank_q};
      `IDX_VBLANK: rd_d = {26'h0000000, vblank_q};
      `IDX_ROT: rd_d = {24'h000000, rot_q};
      `IDX_STRIDE: rd_d = {24'h000000, stride_q};
      `IDX_DISP: rd_d = {30'h00000000, disp_q};
      `IDX_LUT_IDX: rd_d = {28'h0000000, lut_idx_q};
      `IDX_FRAME_SIZE: rd_d = {11'h000, frame_size_q};
      `IDX_LINE_ADDR: rd_d = {15'h0000, line_addr_q};
      `IDX_START: rd_d = {15'h0000, start_q};
      default: rd_d = 32'h00000000;
    endcase
  end

  // refresh variant and divider exponents from the rotation register
  always @* begin
    if (!rot_en) begin
      mode_d = MODE_LAND;
      pix_lg_d = 2'd0;
      mem_lg_d = {1'b0, clk_cfg_q[`CFG_MEM_HALF_BIT]};
    end else if (!rot_alt) begin
      mode_d = MODE_DEF;
      pix_lg_d = sel;
      mem_lg_d = sel;
    end else begin
      mode_d = MODE_ALT;
      pix_lg_d = (sel == 2'd0) ? 2'd1 : sel;
      mem_lg_d = (sel == 2'd0) ? 2'd0 : sel - 2'd1;
    end
  end

  // apb slave: one wait state, write lands on the edge pready is sampled high
  // pready drops after every access, so back-to-back transfers keep the wait state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
      clk_cfg_q <= `REG8_RESET;
      hact_q <= 7'h00;
      vact_lo_q <= `REG8_RESET;
      vact_hi_q <= 2'b00;
      hblank_q <= 5'h00;
      vblank_q <= 6'h00;
      rot_q <= `REG8_RESET;
      stride_q <= `REG8_RESET;
      disp_q <= 2'b00;
      lut_idx_q <= 4'h0;
      start_q <= `START_RESET;
    end else if (clk_en) begin
      pready_q <= acc & ~pready_q;
      if (acc && !pready_q) begin
        prdata_q <= pwrite ? 32'h00000000 : rd_d;
        pslverr_q <= ~mapped(idx);
      end
      if (wr_en) begin
        case (idx)
          `IDX_CLK_CFG: clk_cfg_q <= pwdata[7:0];
          `IDX_HACT: hact_q <= pwdata[6:0];
          `IDX_VACT_LO: vact_lo_q <= pwdata[7:0];
          `IDX_VACT_HI: vact_hi_q <= pwdata[1:0];
          `IDX_HBLANK: hblank_q <= pwdata[4:0];
          `IDX_VBLANK: vblank_q <= pwdata[5:0];
          `IDX_ROT: rot_q <= pwdata[7:0] & `ROT_WMASK;
          `IDX_STRIDE: stride_q <= pwdata[7:0];
          `IDX_DISP: disp_q <= pwdata[1:0];
          `IDX_LUT_IDX: lut_idx_q <= pwdata[3:0];
          `IDX_START: start_q <= pwdata[16:0];
          default: ;
        endcase
      end
    end
  end

  // base divider and aligned pixel/memory clock enables
  // clk_en low holds every register, so a frozen enable pulse may stay high
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_phase_q <= 1'b0;
      div_cnt_q <= 3'b000;
      base_en_q <= 1'b0;
      pix_en_q <= 1'b0;
      mem_en_q <= 1'b0;
      mode_q <= MODE_LAND;
      stride_out_q <= `STRIDE_ZERO;
    end else if (clk_en) begin
      base_phase_q <= ~base_phase_q;
      if (base_tick) begin
        div_cnt_q <= div_cnt_q + 3'b001;
      end
      base_en_q <= base_tick;
      pix_en_q <= pix_tick;
      mem_en_q <= mem_tick;
      mode_q <= mode_d;
      stride_out_q <= stride_d;
    end
  end

  // frame geometry totals
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      h_total_q <= 11'h000;
      v_total_q <= 11'h000;
      frame_size_q <= 21'h000000;
    end else if (clk_en) begin
      h_total_q <= h_act + h_blk;
      v_total_q <= v_act + v_blk;
      frame_size_q <= frame_prod[20:0];
    end
  end

  // pixel and line counters, line start address walk
  // the >= compare lets the counters wrap when the geometry shrinks mid-frame
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hcnt_q <= 11'h000;
      vcnt_q <= 11'h000;
      line_addr_q <= `START_RESET;
      line_q <= 1'b0;
      frame_q <= 1'b0;
    end else if (clk_en) begin
      line_q <= 1'b0;
      frame_q <= 1'b0;
      if (pix_tick) begin
        if (!h_end) begin
          hcnt_q <= hcnt_q + 11'h001;
        end else begin
          hcnt_q <= 11'h000;
          line_q <= 1'b1;
          if (v_end) begin
            vcnt_q <= 11'h000;
            frame_q <= 1'b1;
            line_addr_q <= start_q;
          end else begin
            vcnt_q <= vcnt_q + 11'h001;
            if (rot_en) begin
              line_addr_q <= line_addr_q + {8'h00, stride_d};
            end else begin
              line_addr_q <= line_addr_q + {6'h00, h_act};
            end
          end
        end
      end
    end
  end

  // output stage after the look-up table
  // inversion sits behind the table, so inverted colours need no second table
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lut_v_q <= 1'b0;
      out_v_q <= 1'b0;
      red_q <= 4'h0;
      green_q <= 4'h0;
      blue_q <= 4'h0;
    end else if (clk_en) begin
      lut_v_q <= pixel_valid;
      out_v_q <= lut_v_q;
      if (disp_q[`DISP_MONO_BIT]) begin
        red_q <= lut_rd[7:4] ^ {4{disp_q[`DISP_INV_BIT]}};
        blue_q <= lut_rd[7:4] ^ {4{disp_q[`DISP_INV_BIT]}};
      end else begin
        red_q <= lut_rd[11:8] ^ {4{disp_q[`DISP_INV_BIT]}};
        blue_q <= lut_rd[3:0] ^ {4{disp_q[`DISP_INV_BIT]}};
      end
      green_q <= lut_rd[7:4] ^ {4{disp_q[`DISP_INV_BIT]}};
    end
  end

  // colour table, read data registered inside
  lut_mem u_lut (
    .clk(pclk),
    .rst_n(presetn),
    .clk_en(clk_en),
    .we(lut_we),
    .waddr(lut_idx_q),
    .wdata(pwdata[11:0]),
    .raddr(pixel_in),
    .rdata(lut_rd)
  );

  // every output comes straight from a register
  assign pready = pready_q;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;
  assign base_clk_en = base_en_q;
  assign pixel_clk_en = pix_en_q;
  assign mem_clk_en = mem_en_q;
  assign refresh_mode = mode_q;
  assign line_stride = stride_out_q;
  assign line_addr = line_addr_q;
  assign line_pulse = line_q;
  assign frame_pulse = frame_q;
  assign out_valid = out_v_q;
  assign red_out = red_q;
  assign green_out = green_q;
  assign blue_out = blue_q;
endmodule // rotation_clock_stride_timing

// >>> sim/rcst_sva.sv
// checker: mode, clock enable, stride, apb and pixel path relations at the block ports
// assumes: bound to rotation_clock_stride_timing, single pclk domain, presetn active low
`timescale 1ns/1ns
module rcst_sva (
  input wire pclk, presetn, clk_en, psel, penable, pready, pslverr, pixel_valid, out_valid,
  input wire base_clk_en, pixel_clk_en, mem_clk_en, line_pulse, frame_pulse,
  input wire [1:0] refresh_mode,
  input wire [8:0] line_stride
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // orientation and variant encodings
  AST_MODE_CODE: assert property (refresh_mode != 2'b11)
    else $error("refresh mode code out of range");
  AST_LAND_PIX: assert property (refresh_mode == 2'b00 && $past(refresh_mode, 2) == 2'b00
    |-> pixel_clk_en == base_clk_en) else $error("landscape pixel clock differs from base");
  AST_DEF_MEM: assert property (refresh_mode == 2'b01 && $past(refresh_mode, 2) == 2'b01
    |-> mem_clk_en == pixel_clk_en) else $error("default rotated memory clock differs");
  AST_ALT_MEM: assert property (refresh_mode == 2'b10 && $past(refresh_mode, 2) == 2'b10
    && pixel_clk_en |-> mem_clk_en) else $error("alternate memory clock slower than pixel");
  AST_ALT_PIX: assert property (refresh_mode == 2'b10 && $past(refresh_mode) == 2'b10
    && pixel_clk_en ##1 refresh_mode == 2'b10 |-> !pixel_clk_en)
    else $error("alternate pixel clock faster than half");
  // stride decode range
  AST_STRIDE: assert property (line_stride != 9'h000 && line_stride <= 9'h100)
    else $error("line stride out of range");
  AST_FRAME_LINE: assert property (frame_pulse |-> line_pulse)
    else $error("frame end without line end");
  // bus handshake and pixel latency
  AST_APB_WAIT: assert property (clk_en && psel && penable && !pready |=> pready)
    else $error("ready not given after one wait state");
  AST_APB_PULSE: assert property (pready && clk_en |=> !pready) else $error("ready held too long");
  AST_PIX_LAT: assert property (clk_en && pixel_valid ##1 clk_en |-> ##1 out_valid)
    else $error("pixel output not valid two cycles on");
  CV_ALT: cover property (refresh_mode == 2'b10 && pixel_clk_en);
  CV_FRAME: cover property (frame_pulse);
  CV_ERR: cover property (pready && pslverr);
  CV_S256: cover property (line_stride == 9'h100 && line_pulse);
endmodule // rcst_sva
bind rotation_clock_stride_timing rcst_sva u_sva (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .pixel_valid(pixel_valid),
  .out_valid(out_valid), .base_clk_en(base_clk_en), .pixel_clk_en(pixel_clk_en),
  .mem_clk_en(mem_clk_en), .line_pulse(line_pulse), .frame_pulse(frame_pulse),
  .refresh_mode(refresh_mode), .line_stride(line_stride));

// >>> sim/lcd_panel_model.sv
// panel side model: measures line and frame length and line start stepping
// assumes: refresh pulses are single-cycle and registered on pclk
`timescale 1ns/1ns
module lcd_panel_model (
  input wire pclk,
  input wire presetn,
  input wire line_pulse,
  input wire frame_pulse,
  input wire [16:0] line_addr,
  output reg [15:0] line_len,
  output reg [15:0] frame_len,
  output reg [16:0] addr_delta
);
  reg [15:0] lcnt;
  reg [15:0] fcnt;
  reg [16:0] last_addr;
  reg first;
  // cycle counters between line and frame marks
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lcnt <= 16'h0000;
      fcnt <= 16'h0000;
      line_len <= 16'h0000;
      frame_len <= 16'h0000;
      addr_delta <= 17'h00000;
      last_addr <= 17'h00000;
      first <= 1'b1;
    end else begin
      lcnt <= line_pulse ? 16'h0000 : lcnt + 16'h0001;
      fcnt <= frame_pulse ? 16'h0000 : fcnt + 16'h0001;
      if (line_pulse) begin
        line_len <= lcnt + 16'h0001;
        last_addr <= line_addr;
        first <= frame_pulse;
        if (!first && !frame_pulse) addr_delta <= line_addr - last_addr;
      end
      if (frame_pulse) frame_len <= fcnt + 16'h0001;
    end
  end
endmodule // lcd_panel_model

// >>> sim/rotation_clock_stride_timing_tb.sv
// testbench: apb register access, clock divider table, frame timing, stride, pixel path
// assumes: register byte address is index * 4, one apb wait state
`timescale 1ns/1ns
`include "rot_defines.vh"
module rotation_clock_stride_timing_tb;
  reg pclk, presetn, clk_en, psel, penable, pwrite, pixel_valid, err;
  reg [9:0] paddr;
  reg [31:0] pwdata, rd;
  reg [3:0] pixel_in;
  reg [7:0] r, c;
  wire pready, pslverr, base_clk_en, pixel_clk_en, mem_clk_en, line_pulse, frame_pulse, out_valid;
  wire [31:0] prdata;
  wire [1:0] refresh_mode;
  wire [8:0] line_stride;
  wire [16:0] line_addr, addr_delta;
  wire [3:0] red_out, green_out, blue_out;
  wire [15:0] line_len, frame_len;
  integer bad_count, check_count, i, np, nm, p, m;
  rotation_clock_stride_timing u_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .pixel_valid(pixel_valid), .pixel_in(pixel_in),
    .base_clk_en(base_clk_en), .pixel_clk_en(pixel_clk_en), .mem_clk_en(mem_clk_en),
    .refresh_mode(refresh_mode), .line_stride(line_stride), .line_addr(line_addr),
    .line_pulse(line_pulse), .frame_pulse(frame_pulse), .out_valid(out_valid),
    .red_out(red_out), .green_out(green_out), .blue_out(blue_out));
  lcd_panel_model u_panel (.pclk(pclk), .presetn(presetn), .line_pulse(line_pulse),
    .frame_pulse(frame_pulse), .line_addr(line_addr), .line_len(line_len),
    .frame_len(frame_len), .addr_delta(addr_delta));
  // clock source
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // one apb transfer, held until ready
  task apb(input [7:0] idx, input w, input [31:0] d);
    integer n;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 40) begin
        n = n + 1;
        @(posedge pclk);
      end
      if (n == 40) bad_count = bad_count + 1;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // wait for three frame ends, bounded
  task wf;
    integer n;
    begin
      repeat (3) begin
        n = 0;
        @(posedge pclk);
        while (frame_pulse !== 1'b1 && n < 5000) begin
          n = n + 1;
          @(posedge pclk);
        end
        if (n == 5000) bad_count = bad_count + 1;
      end
    end
  endtask
  task print_verdict;
    begin
      $display("checks=%0d errors=%0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // watchdog
  initial begin
    #1500000;
    bad_count = bad_count + 1;
    print_verdict;
  end
  // main sequence
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, pixel_valid, paddr, pwdata, pixel_in} = 0;
    clk_en = 1'b1;
    bad_count = 0;
    check_count = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(`IDX_STRIDE, 1'b0, 32'h0);
    chk({rd[30:0], err}, 32'h0);
    chk(line_stride, 32'h100);
    for (i = 0; i < 2; i = i + 1) begin
      apb(`IDX_STRIDE, 1'b1, i ? 32'hff : 32'h01);
      apb(`IDX_STRIDE, 1'b0, 32'h0);
      chk(rd, i ? 32'hff : 32'h01);
      chk(line_stride, i ? 32'hff : 32'h01);
    end
    for (i = 0; i < 40; i = i + 1) begin
      r = (i / 4 < 2) ? (i / 4) * 3 : ((i / 4 < 6) ? 8'h7e + i / 4 : 8'hba + i / 4);
      c = (i % 4) << 4;
      apb(`IDX_CLK_CFG, 1'b1, c);
      apb(`IDX_ROT, 1'b1, r);
      p = r[7] ? ((r[6] && r[1:0] == 2'b00) ? 2 : 1 << r[1:0]) : 1;
      m = r[7] ? (r[6] ? p / 2 : p) : (c[5] ? 2 : 1);
      p = p << c[4];
      m = m << c[4];
      repeat (8) @(posedge pclk);
      np = 0;
      nm = 0;
      repeat (256) begin
        @(posedge pclk);
        np = np + pixel_clk_en;
        nm = nm + mem_clk_en;
      end
      chk(np, 256 / p);
      chk(nm, 256 / m);
    end
    apb(`IDX_ROT, 1'b0, 32'h0);
    chk(rd, 32'hc3);
    apb(`IDX_CLK_CFG, 1'b1, 32'h0);
    apb(`IDX_ROT, 1'b1, 32'h0);
    apb(`IDX_HACT, 1'b1, 32'h1);
    apb(`IDX_HBLANK, 1'b1, 32'h1);
    apb(`IDX_VACT_LO, 1'b1, 32'h1);
    apb(`IDX_VBLANK, 1'b1, 32'h2);
    wf;
    chk(line_len, 32'd56);
    chk(frame_len, 32'd224);
    apb(`IDX_FRAME_SIZE, 1'b0, 32'h0);
    chk(rd, 32'd224);
    apb(`IDX_VACT_HI, 1'b1, 32'h1);
    apb(`IDX_FRAME_SIZE, 1'b0, 32'h0);
    chk(rd, 32'd14560);
    apb(`IDX_VACT_HI, 1'b1, 32'h0);
    apb(`IDX_ROT, 1'b1, 32'h80);
    for (i = 0; i < 2; i = i + 1) begin
      apb(`IDX_STRIDE, 1'b1, i ? 32'h0 : 32'h10);
      wf;
      chk(addr_delta, i ? 32'h100 : 32'h10);
    end
    // freeze: no line may advance while clk_en is low
    @(posedge pclk);
    clk_en <= 1'b0;
    @(posedge pclk);
    rd = {15'h0000, line_addr};
    repeat (300) @(posedge pclk);
    chk(line_addr, rd);
    clk_en <= 1'b1;
    apb(`IDX_LUT_IDX, 1'b1, 32'h5);
    apb(`IDX_LUT_DATA, 1'b1, 32'h3a7);
    for (i = 0; i < 2; i = i + 1) begin
      apb(`IDX_DISP, 1'b1, i * 3);
      @(posedge pclk);
      pixel_valid <= 1'b1;
      pixel_in <= 4'h5;
      @(posedge pclk);
      pixel_valid <= 1'b0;
      @(posedge pclk);
      #1 chk({out_valid, red_out, green_out, blue_out}, i ? 32'h1555 : 32'h13a7);
    end
    apb(`IDX_TEST_A, 1'b0, 32'h0);
    chk({rd[30:0], err}, 32'h0);
    apb(8'h30, 1'b0, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    print_verdict;
  end
endmodule // rotation_clock_stride_timing_tb
